// *** pkg/itpc_pkg.sv ***
// package: register map, reset values and timing constants for the i2c timing and port control block
package itpc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam logic [7:0] ADDR_I2C_CTL2 = 8'h09;
	localparam logic [7:0] ADDR_SCL_HIGH = 8'h0a;
	localparam logic [7:0] ADDR_SCL_LOW = 8'h0b;
	localparam logic [7:0] ADDR_RECEIVER_PORT_CONTROL = 8'h0c;
	localparam logic [7:0] RST_I2C_CTL2 = 8'h10;
	localparam logic [7:0] RST_SCL_HIGH = 8'h7a;
	localparam logic [7:0] RST_SCL_LOW = 8'h7a;
	localparam logic [1:0] RST_RX_RSVD = 2'h2;
	localparam logic [1:0] RST_PASS_SEL = 2'h0;
	localparam logic [1:0] RST_LOCK_SEL = 2'h0;
	localparam logic [1:0] RST_PORT_EN = 2'h3;
	localparam int unsigned CTL2_SETUP_LSB = 4;
	localparam int unsigned CTL2_DELAY_LSB = 2;
	localparam int unsigned CTL2_FAST_BIT = 1;
	localparam int unsigned CTL2_DIS_BIT = 0;
	localparam int unsigned RX_PASS_LSB = 4;
	localparam int unsigned RX_LOCK_LSB = 2;
	// timing figures in ns, us and ms as printed
	localparam int unsigned SETUP_BASE_NS = 80;
	localparam int unsigned SETUP_STEP_NS = 640;
	localparam int unsigned DELAY_BASE_NS = 240;
	localparam int unsigned DELAY_STEP_NS = 40;
	localparam int unsigned SCL_UNIT_NS = 40;
	localparam int unsigned SCL_EXTRA_UNITS = 4;
	localparam int unsigned WD_FAST_US = 50;
	localparam int unsigned WD_SLOW_MS = 1000;
	localparam int unsigned RECOVER_PULSES = 9;
	// cycle counts at 125 MHz
	localparam int unsigned SETUP_BASE_CYC = (SETUP_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SETUP_STEP_CYC = (SETUP_STEP_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned DELAY_BASE_CYC = (DELAY_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DELAY_STEP_CYC = (DELAY_STEP_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned SCL_UNIT_CYC = (SCL_UNIT_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned WD_FAST_CYC = (WD_FAST_US * 1000000) / CLK_PERIOD_PS;
	localparam int unsigned WD_SLOW_CYC = 125000000 / 1000 * WD_SLOW_MS;
endpackage

// *** hdl/itpc_pulse_timer.sv ***
// interval timer: loads a cycle count and pulses when it runs out
`timescale 1ns/1ps
module itpc_pulse_timer #(
	parameter int W = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d;

	always_comb
	begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (load)
		begin
			cnt_d = count;
			busy_d = 1'b1;
		end
		else if (busy_q)
		begin
			if (cnt_q <= W'(1))
			begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
			else
				cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (clkEn)
		begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
endmodule

// *** hdl/itpc_top.sv ***
// i2c timing registers, bus watchdog with recovery, scl clock generator and lock/pass selection
// Contract
// - ack sda setup is 80ns plus 640ns steps up to 255 cycles
// - sda output delay 240ns plus 40ns steps
// - watchdog expires 50us fast, else one second
// - sda high idle to expiry means bus free
// - sda low idle to expiry drives nine clocks
// - scl high is 40ns times (setting+4)
// - scl low is 40ns times (setting+4)
// - target sda setup reuses scl low setting
// - pass source port0, port1, any or all
// - lock source port0, port1, any or all
// - remote writes cannot change pass/lock select
// - two port enables, both reset enabled
`timescale 1ns/1ps
module itpc_top #(
	parameter int unsigned WD_SLOW_CYCLES = itpc_pkg::WD_SLOW_CYC,
	parameter int unsigned WD_FAST_CYCLES = itpc_pkg::WD_FAST_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic regWrite,
	input wire logic regRemote,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sclGenStart,
	input wire logic sclGenStop,
	input wire logic [1:0] portLock,
	input wire logic [1:0] portPass,
	output logic sclOut,
	output logic sclOe,
	output logic busFree,
	output logic lockOut,
	output logic passOut,
	output logic [1:0] receiverOn,
	output logic [7:0] ackSetupCycles,
	output logic [7:0] sdaDelayCycles,
	output logic [15:0] targetSetupCycles
);
	// ****************************************
	// register file
	// ****************************************
	logic [7:0] ctl2_q, ctl2_d, sclHigh_q, sclHigh_d, sclLow_q, sclLow_d;
	logic [1:0] passSel_q, passSel_d, lockSel_q, lockSel_d, portEn_q, portEn_d;
	logic [7:0] rdata_q, rdata_d;

	function automatic logic [15:0] scl_cycles(input logic [7:0] setting);
		scl_cycles = 16'((32'(setting) + itpc_pkg::SCL_EXTRA_UNITS) * itpc_pkg::SCL_UNIT_CYC);
	endfunction

	function automatic logic select_src(input logic [1:0] sel, input logic [1:0] st, input logic [1:0] en);
		case (sel)
			2'h0: select_src = st[0];
			2'h1: select_src = st[1];
			2'h2: select_src = |(st & en);
			2'h3: select_src = (en != 2'h0) && ((st & en) == en);
			default: select_src = 1'b0;
		endcase
	endfunction

	// long setup fields would wrap in 8 bits, so the count pins at its top value instead
	function automatic logic [7:0] cycles_sat8(input int unsigned base, input int unsigned step,
		input logic [3:0] field);
		int unsigned total;
		total = base + 32'(field) * step;
		cycles_sat8 = (total > 32'h0000_00ff) ? 8'hff : 8'(total);
	endfunction

	always_comb
	begin
		ctl2_d = ctl2_q;
		sclHigh_d = sclHigh_q;
		sclLow_d = sclLow_q;
		passSel_d = passSel_q;
		lockSel_d = lockSel_q;
		portEn_d = portEn_q;
		if (regWrite)
		begin
			case (regAddr)
				itpc_pkg::ADDR_I2C_CTL2: ctl2_d = regWdata;
				itpc_pkg::ADDR_SCL_HIGH: sclHigh_d = regWdata;
				itpc_pkg::ADDR_SCL_LOW: sclLow_d = regWdata;
				itpc_pkg::ADDR_RECEIVER_PORT_CONTROL:
				begin
					portEn_d = regWdata[1:0];
					if (!regRemote)
					begin
						passSel_d = regWdata[itpc_pkg::RX_PASS_LSB +: 2];
						lockSel_d = regWdata[itpc_pkg::RX_LOCK_LSB +: 2];
					end
				end
				default: ;
			endcase
		end
		case (regAddr)
			itpc_pkg::ADDR_I2C_CTL2: rdata_d = ctl2_q;
			itpc_pkg::ADDR_SCL_HIGH: rdata_d = sclHigh_q;
			itpc_pkg::ADDR_SCL_LOW: rdata_d = sclLow_q;
			itpc_pkg::ADDR_RECEIVER_PORT_CONTROL: rdata_d = {itpc_pkg::RST_RX_RSVD, passSel_q, lockSel_q, portEn_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctl2_q <= itpc_pkg::RST_I2C_CTL2;
			sclHigh_q <= itpc_pkg::RST_SCL_HIGH;
			sclLow_q <= itpc_pkg::RST_SCL_LOW;
			passSel_q <= itpc_pkg::RST_PASS_SEL;
			lockSel_q <= itpc_pkg::RST_LOCK_SEL;
			portEn_q <= itpc_pkg::RST_PORT_EN;
			rdata_q <= 8'h00;
		end
		else if (clkEn)
		begin
			ctl2_q <= ctl2_d;
			sclHigh_q <= sclHigh_d;
			sclLow_q <= sclLow_d;
			passSel_q <= passSel_d;
			lockSel_q <= lockSel_d;
			portEn_q <= portEn_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// watchdog and scl generator
	// ****************************************
	typedef enum logic [3:0] {
		ITPC_IDLE = 4'b0001,
		ITPC_LOW = 4'b0010,
		ITPC_HIGH = 4'b0100,
		ITPC_WAIT = 4'b1000
	} itpc_state_t;

	itpc_state_t state_q, state_d;
	logic [27:0] wd_q, wd_d;
	logic [3:0] pulses_q, pulses_d;
	logic recov_q, recov_d, free_q, free_d, scl_q, scl_d, oe_q, oe_d;
	logic sclPrev_q, sdaPrev_q;
	logic lock_q, pass_q;
	logic [7:0] ackSetup_q, sdaDelay_q;
	logic [15:0] tgtSetup_q;
	logic tLoad, tBusy, tDone;
	logic [15:0] tCount;
	logic wdEn, activity;
	logic [27:0] wdLimit;

	assign wdEn = !ctl2_q[itpc_pkg::CTL2_DIS_BIT];
	// fast mode shortens expiry for test and quick recovery
	assign wdLimit = ctl2_q[itpc_pkg::CTL2_FAST_BIT] ? 28'(WD_FAST_CYCLES) : 28'(WD_SLOW_CYCLES);
	assign activity = (sclIn != sclPrev_q) || (sdaIn != sdaPrev_q) || state_q != ITPC_IDLE;

	itpc_pulse_timer #(.W(16)) u_timer (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clkEn(clkEn),
		.load(tLoad),
		.count(tCount),
		.busy(tBusy),
		.done(tDone)
	);

	always_comb
	begin
		state_d = state_q;
		wd_d = wd_q;
		pulses_d = pulses_q;
		recov_d = recov_q;
		free_d = free_q;
		scl_d = scl_q;
		oe_d = oe_q;
		tLoad = 1'b0;
		// timer done is registered and acted on one edge later, so the low phase loads one short and the high phase two short
		tCount = scl_cycles(sclLow_q) - 16'd1;
		if (!wdEn)
		begin
			wd_d = '0;
			free_d = 1'b0;
		end
		else if (activity)
		begin
			wd_d = '0;
			free_d = 1'b0;
		end
		else if (wd_q < wdLimit)
			wd_d = wd_q + 28'd1;
		case (state_q)
			ITPC_IDLE:
			begin
				if (wdEn && !activity && wd_q == wdLimit - 28'd1)
				begin
					if (sdaIn)
						free_d = 1'b1;
					else
					begin
						recov_d = 1'b1;
						pulses_d = 4'(itpc_pkg::RECOVER_PULSES);
						state_d = ITPC_LOW;
						scl_d = 1'b0;
						oe_d = 1'b1;
						tLoad = 1'b1;
					end
				end
				else if (sclGenStart)
				begin
					recov_d = 1'b0;
					state_d = ITPC_LOW;
					scl_d = 1'b0;
					oe_d = 1'b1;
					tLoad = 1'b1;
				end
			end
			ITPC_LOW:
				if (tDone)
				begin
					state_d = ITPC_HIGH;
					scl_d = 1'b1;
					oe_d = 1'b0;
					// the pause state supplies the last cycle of the high phase
					tCount = scl_cycles(sclHigh_q) - 16'd2;
					tLoad = 1'b1;
				end
			ITPC_HIGH:
				if (tDone)
				begin
					if (recov_q && pulses_q <= 4'd1)
					begin
						recov_d = 1'b0;
						pulses_d = 4'd0;
						state_d = ITPC_IDLE;
					end
					else if (!recov_q && sclGenStop)
						state_d = ITPC_IDLE;
					else
					begin
						if (recov_q)
							pulses_d = pulses_q - 4'd1;
						state_d = ITPC_WAIT;
					end
				end
			ITPC_WAIT:
			begin
				state_d = ITPC_LOW;
				scl_d = 1'b0;
				oe_d = 1'b1;
				tCount = scl_cycles(sclLow_q) - 16'd1;
				tLoad = 1'b1;
			end
			default: state_d = ITPC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ITPC_IDLE;
			wd_q <= '0;
			pulses_q <= 4'd0;
			recov_q <= 1'b0;
			free_q <= 1'b0;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			lock_q <= 1'b0;
			pass_q <= 1'b0;
			ackSetup_q <= 8'd0;
			sdaDelay_q <= 8'd0;
			tgtSetup_q <= 16'd0;
		end
		else if (clkEn)
		begin
			state_q <= state_d;
			wd_q <= wd_d;
			pulses_q <= pulses_d;
			recov_q <= recov_d;
			free_q <= free_d;
			scl_q <= scl_d;
			oe_q <= oe_d;
			sclPrev_q <= sclIn;
			sdaPrev_q <= sdaIn;
			lock_q <= select_src(lockSel_q, portLock, portEn_q);
			pass_q <= select_src(passSel_q, portPass, portEn_q);
			ackSetup_q <= cycles_sat8(itpc_pkg::SETUP_BASE_CYC, itpc_pkg::SETUP_STEP_CYC, ctl2_q[7:4]);
			sdaDelay_q <= cycles_sat8(itpc_pkg::DELAY_BASE_CYC, itpc_pkg::DELAY_STEP_CYC, {2'b00, ctl2_q[3:2]});
			tgtSetup_q <= scl_cycles(sclLow_q);
		end
	end

	assign regRdata = rdata_q;
	assign sclOut = scl_q;
	assign sclOe = oe_q;
	assign busFree = free_q;
	assign lockOut = lock_q;
	assign passOut = pass_q;
	assign receiverOn = portEn_q;
	assign ackSetupCycles = ackSetup_q;
	assign sdaDelayCycles = sdaDelay_q;
	assign targetSetupCycles = tgtSetup_q;

	// ****************************************
	// checks
	// ****************************************
	property p_remote_sel;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && regWrite && regRemote && regAddr == itpc_pkg::ADDR_RECEIVER_PORT_CONTROL) |=> $stable(passSel_q) && $stable(lockSel_q);
	endproperty
	a_remote_sel: assert property (p_remote_sel) else $error("remote write changed select");

	property p_lock_any;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && lockSel_q == 2'h2) |=> (lockOut == |($past(portLock) & $past(portEn_q))) || !clkEn;
	endproperty
	a_lock_any: assert property (p_lock_any) else $error("lock any mismatch");

	property p_pass_p1;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && passSel_q == 2'h1) |=> (passOut == $past(portPass[1])) || !clkEn;
	endproperty
	a_pass_p1: assert property (p_pass_p1) else $error("pass port1 mismatch");

	property p_disabled_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && !wdEn && state_q == ITPC_IDLE && !sclGenStart) |=> !busFree && !recov_q;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("watchdog acted while disabled");

	property p_recover_start;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && state_q == ITPC_IDLE && wdEn && !activity && wd_q == wdLimit - 28'd1 && !sdaIn) |=> recov_q && sclOe && pulses_q == 4'd9;
	endproperty
	a_recover_start: assert property (p_recover_start) else $error("recovery did not start with nine pulses");

	property p_free;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && state_q == ITPC_IDLE && wdEn && !activity && wd_q == wdLimit - 28'd1 && sdaIn) |=> busFree;
	endproperty
	a_free: assert property (p_free) else $error("bus free not flagged");

	property p_fast;
		@(posedge ref_clk) disable iff (!nrst)
		(clkEn && ctl2_q[itpc_pkg::CTL2_FAST_BIT] && wdEn && state_q == ITPC_IDLE && !activity && sdaIn
			&& wd_q == 28'(WD_FAST_CYCLES) - 28'd1) |=> busFree;
	endproperty
	a_fast: assert property (p_fast) else $error("fast expiry did not flag bus free");

	property p_low_timed;
		@(posedge ref_clk) disable iff (!nrst)
		(state_q == ITPC_LOW) |-> tBusy || tDone;
	endproperty
	a_low_timed: assert property (p_low_timed) else $error("scl low phase without running timer");

	property p_en_reset;
		@(posedge ref_clk) $rose(nrst) |-> receiverOn == 2'h3;
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("ports not enabled at reset");

	c_recover: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(recov_q));
	c_free: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(busFree));
	c_gen: cover property (@(posedge ref_clk) disable iff (!nrst) state_q == ITPC_HIGH && !recov_q);
endmodule

// *** tb/itpc_bus_model.sv ***
// local i2c bus model: pull-ups on both lines and a target that can hold sda low
`timescale 1ns/1ps
module itpc_bus_model (
	input wire logic sclOe,
	input wire logic sdaHold,
	output logic sclIn,
	output logic sdaIn
);
	// open drain: a released line returns to its pull-up, never to its last value
	assign sclIn = sclOe ? 1'b0 : 1'b1;
	// bus timing comes from ref_clk here, so the oscillator drift allowance is never consumed
	assign sdaIn = sdaHold ? 1'b0 : 1'b1;
endmodule

// *** tb/itpc_top_tb.sv ***
// self-checking bench for the i2c timing and port control block
`timescale 1ns/1ps
module itpc_top_tb;
	localparam int WD_SLOW = 200;
	localparam int WD_FAST = 50;
	logic ref_clk, nrst, clkEn, regWrite, regRemote, sclGenStart, sclGenStop, sdaHold;
	logic [7:0] regAddr, regWdata, regRdata, ackSetupCycles, sdaDelayCycles;
	logic [1:0] portLock, portPass, receiverOn;
	logic sclIn, sdaIn, sclOut, sclOe, busFree, lockOut, passOut;
	logic [15:0] targetSetupCycles;
	int failCount = 0;
	int numChecks = 0;

	itpc_top #(.WD_SLOW_CYCLES(WD_SLOW), .WD_FAST_CYCLES(WD_FAST)) dut (.ref_clk(ref_clk), .nrst(nrst),
		.clkEn(clkEn), .regWrite(regWrite), .regRemote(regRemote), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .sclIn(sclIn), .sdaIn(sdaIn), .sclGenStart(sclGenStart), .sclGenStop(sclGenStop),
		.portLock(portLock), .portPass(portPass), .sclOut(sclOut), .sclOe(sclOe), .busFree(busFree),
		.lockOut(lockOut), .passOut(passOut), .receiverOn(receiverOn), .ackSetupCycles(ackSetupCycles),
		.sdaDelayCycles(sdaDelayCycles), .targetSetupCycles(targetSetupCycles));
	itpc_bus_model model (.sclOe(sclOe), .sdaHold(sdaHold), .sclIn(sclIn), .sdaIn(sdaIn));

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ****************
	// shared tasks
	// ****************
	task automatic finish_test;
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			failCount++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic do_reset;
		@(posedge ref_clk);
		nrst <= 1'b0;
		sdaHold <= 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic remote = 1'b0);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regRemote <= remote;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		regRemote <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		cyc(2);
		d = regRdata;
	endtask

	// cycles spent while scl pull-down equals lvl, bounded
	task automatic run(input logic lvl, output int n);
		n = 0;
		while (sclOe === lvl && n < 1000)
		begin
			cyc(1);
			n++;
		end
	endtask

	// holds sda low for a window and counts recovery pulses
	task automatic hang(input int len, output int rises);
		logic prev;
		rises = 0;
		prev = 1'b0;
		@(posedge ref_clk);
		sdaHold <= 1'b1;
		for (int i = 0; i < len; i++)
		begin
			cyc(1);
			if (sclOe === 1'b1 && prev === 1'b0)
				rises++;
			prev = sclOe;
		end
		@(posedge ref_clk);
		sdaHold <= 1'b0;
	endtask

	function automatic logic pick(input int s, input logic [1:0] en, input logic [1:0] p);
		case (s)
			0: return p[0];
			1: return p[1];
			2: return |(p & en);
			default: return (en != 2'b00) && (&(p | ~en));
		endcase
	endfunction

	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		logic [7:0] d;
		rd(8'h09, d);
		chk("ctl2 reset", 16'(d), 16'h0010);
		rd(8'h0a, d);
		chk("high reset", 16'(d), 16'h007a);
		rd(8'h0b, d);
		chk("low reset", 16'(d), 16'h007a);
		rd(8'h0c, d);
		chk("port ctl reset", 16'(d), 16'h0083);
		rd(8'h20, d);
		chk("unmapped read", 16'(d), 16'h0000);
		chk("receivers on", 16'(receiverOn), 16'h0003);
		chk("scl out reset", 16'(sclOut), 16'h0001);
	endtask

	task automatic t_timing;
		logic [7:0] d;
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h09, {f[3:0], f[1:0], 2'b01});
			rd(8'h09, d);
			chk("ctl2 readback", 16'(d), 16'({f[3:0], f[1:0], 2'b01}));
			chk("ack setup", 16'(ackSetupCycles), 16'(itpc_pkg::SETUP_BASE_CYC + f * itpc_pkg::SETUP_STEP_CYC));
			chk("sda delay", 16'(sdaDelayCycles), 16'(itpc_pkg::DELAY_BASE_CYC + f * itpc_pkg::DELAY_STEP_CYC));
		end
		wr(8'h0b, 8'h10);
		cyc(3);
		chk("target setup", targetSetupCycles, 16'(20 * itpc_pkg::SCL_UNIT_CYC));
		wr(8'h09, 8'hf1);
		cyc(2);
		chk("ack setup top", 16'(ackSetupCycles), 16'h00ff);
		// a write while the clock enable is low must leave the register alone
		@(posedge ref_clk);
		clkEn <= 1'b0;
		wr(8'h0b, 8'h55);
		clkEn <= 1'b1;
		rd(8'h0b, d);
		chk("frozen write", 16'(d), 16'h0010);
	endtask

	task automatic t_select;
		logic [1:0] en;
		logic [7:0] d;
		for (int s = 0; s < 4; s++)
			for (int k = 0; k < 2; k++)
				for (int v = 0; v < 4; v++)
				begin
					en = k ? 2'b11 : 2'b10;
					wr(8'h0c, {2'b10, s[1:0], s[1:0], en});
					portLock <= v[1:0];
					portPass <= ~v[1:0];
					cyc(3);
					chk("receiver on", 16'(receiverOn), 16'(en));
					chk("lock out", 16'(lockOut), 16'(pick(s, en, v[1:0])));
					chk("pass out", 16'(passOut), 16'(pick(s, en, ~v[1:0])));
				end
		// remote write: selections stay, enables follow
		wr(8'h0c, 8'hb1, 1'b1);
		rd(8'h0c, d);
		chk("remote write", 16'(d), 16'h00bd);
		chk("remote enable", 16'(receiverOn), 16'h0001);
	endtask

	task automatic t_clock;
		int n;
		wr(8'h09, 8'h11);
		wr(8'h0a, 8'h06);
		wr(8'h0b, 8'h02);
		sclGenStart <= 1'b1;
		@(posedge ref_clk);
		sclGenStart <= 1'b0;
		#1;
		run(1'b0, n);
		run(1'b1, n);
		chk("scl low width", 16'(n), 16'(6 * itpc_pkg::SCL_UNIT_CYC));
		run(1'b0, n);
		chk("scl high width", 16'(n), 16'(10 * itpc_pkg::SCL_UNIT_CYC));
		@(posedge ref_clk);
		sclGenStop <= 1'b1;
		// land inside the last high phase, then no further low may follow
		cyc(60);
		run(1'b0, n);
		chk("scl stopped", 16'(n), 16'h03e8);
		chk("scl out idle", 16'(sclOut), 16'h0001);
		@(posedge ref_clk);
		sclGenStop <= 1'b0;
	endtask

	task automatic t_watch;
		int n;
		for (int fast = 0; fast < 2; fast++)
		begin
			do_reset();
			if (fast)
				wr(8'h09, 8'h12);
			n = 0;
			while (busFree !== 1'b1 && n < 1000)
			begin
				cyc(1);
				n++;
			end
			// expiry counted from reset release, a few cycles of slack for pipelining
			chk("bus free time", 16'(n > (fast ? WD_FAST : WD_SLOW) - 8 && n < (fast ? WD_FAST : WD_SLOW) + 8), 16'h0001);
		end
		do_reset();
		wr(8'h09, 8'h12);
		wr(8'h0b, 8'h02);
		wr(8'h0a, 8'h02);
		hang(620, n);
		chk("recovery pulses", 16'(n), 16'h0009);
		do_reset();
		// fast expiry armed, so a live watchdog would act well inside these windows
		wr(8'h09, 8'h13);
		hang(400, n);
		cyc(80);
		chk("disabled pulses", 16'(n), 16'h0000);
		chk("disabled free", 16'(busFree), 16'h0000);
	endtask

	initial
	begin
		nrst = 1'b0;
		clkEn = 1'b1;
		regWrite = 1'b0;
		regRemote = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		sclGenStart = 1'b0;
		sclGenStop = 1'b0;
		sdaHold = 1'b0;
		portLock = 2'b00;
		portPass = 2'b00;
		do_reset();
		t_reset();
		t_timing();
		t_select();
		t_clock();
		t_watch();
		finish_test();
	end

	// watchdog: the full run needs well under 10000 cycles
	initial
	begin
		#200000;
		failCount++;
		finish_test();
	end
endmodule
